// ===== verilog/vsdbg_pkg.sv
// Shared constants and carrier types for the video stream debug unit
`default_nettype none
package vsdbg_pkg;
  // --------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------
  localparam logic [7:0]  OFS_CONTROL   = 8'h00;
  localparam logic [7:0]  OFS_ERROR     = 8'h08;
  localparam logic [7:0]  OFS_FRAME_CNT = 8'h14;
  localparam logic [7:0]  OFS_LINE_CNT  = 8'h18;
  localparam logic [7:0]  OFS_PIXEL_CNT = 8'h1c;
  localparam logic [7:0]  OFS_SIZE      = 8'h20;
  localparam int          BIT_BYPASS    = 4;
  localparam int          BIT_PATTERN   = 5;
  localparam int          BIT_SHORT     = 0;
  localparam int          BIT_LONG      = 1;
  localparam int          BIT_SOF_EARLY = 2;
  localparam int          BIT_SOF_LATE  = 3;
  localparam logic [15:0] COLS_RESET    = 16'h0780;
  localparam logic [15:0] ROWS_RESET    = 16'h0438;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  // --------------------------------------------------------------------
  // Pattern geometry, pixel and counter widths
  // --------------------------------------------------------------------
  localparam int          BAR_LINES     = 256;
  localparam int          BAR_WIDTH     = 64;
  localparam int          BAR_SHIFT     = $clog2(BAR_WIDTH);
  localparam int          DATA_W        = 24;
  localparam int          CNT_W         = 32;
  // --------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [DATA_W-1:0] tdata;
    logic              tuser;
    logic              tlast;
  } vsdbg_beat_t;

  typedef struct packed {
    logic        bypass;
    logic        pattern;
    logic [15:0] cols;
    logic [15:0] rows;
    logic [3:0]  err;
    logic        bValid;
    logic        rValid;
    logic [31:0] rData;
    logic [15:0] col;
    logic [15:0] row;
    logic        drop;
    logic        oValid;
    vsdbg_beat_t oBeat;
  } vsdbg_core_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] col;
    logic [15:0] row;
    vsdbg_beat_t beat;
  } vsdbg_gen_t;
endpackage
`default_nettype wire

// ===== verilog/vsdbg_pattern.sv
// Colour-bar and ramp test-pattern source
`timescale 1ns/1ps
`default_nettype none
module vsdbg_pattern import vsdbg_pkg::*; (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        enable,
  input  wire logic [15:0] cols,
  input  wire logic [15:0] rows,
  input  wire logic        ready,
  output logic             valid,
  output vsdbg_beat_t      beat
);
  // --------------------------------------------------------------------
  // Pixel colour
  // --------------------------------------------------------------------
  function automatic logic [DATA_W-1:0] pixel(input logic [15:0] c, input logic [15:0] r);
    logic [2:0] idx;
    logic [7:0] gray;
    idx  = 3'(c >> BAR_SHIFT);
    gray = 8'(c[7:0] + r[7:0]);
    if (r < 16'(BAR_LINES)) begin
      // Order black, red, green, yellow, blue, magenta, cyan, white
      pixel = {{8{idx[0]}}, {8{idx[1]}}, {8{idx[2]}}};
    end else begin
      pixel = {gray, gray, gray};
    end
  endfunction

  vsdbg_gen_t s_q;
  vsdbg_gen_t s_d;

  always_comb begin
    s_d = s_q;
    if (!enable) begin
      // Restart at frame start so every enable begins with a clean frame
      s_d = '0;
    end else if (!s_q.valid || ready) begin
      s_d.valid      = 1'b1;
      s_d.beat.tdata = pixel(s_q.col, s_q.row);
      s_d.beat.tuser = (s_q.col == 16'h0000) && (s_q.row == 16'h0000);
      s_d.beat.tlast = (s_q.col >= 16'(cols - 16'h0001));
      if (s_d.beat.tlast) begin
        s_d.col = 16'h0000;
        s_d.row = (s_q.row >= 16'(rows - 16'h0001)) ? 16'h0000 : 16'(s_q.row + 16'h0001);
      end else begin
        s_d.col = 16'(s_q.col + 16'h0001);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign valid = s_q.valid;
  assign beat  = s_q.beat;
endmodule
`default_nettype wire

// ===== verilog/vsdbg_tput.sv
// Frame, line and pixel throughput counters
`timescale 1ns/1ps
`default_nettype none
module vsdbg_tput import vsdbg_pkg::*; #(
  parameter int W = CNT_W
) (
  input  wire logic         ref_clk,
  input  wire logic         reset,
  input  wire logic         fire,
  input  wire logic         sof,
  input  wire logic         eol,
  output logic [W-1:0]      frames,
  output logic [W-1:0]      lines,
  output logic [W-1:0]      pixels
);
  typedef struct packed {
    logic [W-1:0] frames;
    logic [W-1:0] lines;
    logic [W-1:0] pixels;
  } vsdbg_cnt_t;

  vsdbg_cnt_t c_q;
  vsdbg_cnt_t c_d;

  if (W < 1) begin : g_chk
    $error("vsdbg_tput: counter width must be positive");
  end

  // Free-running: wraps to zero, only a core reset clears it
  always_comb begin
    c_d = c_q;
    if (fire) begin
      c_d.pixels = W'(c_q.pixels + 1'b1);
      if (eol) begin
        c_d.lines = W'(c_q.lines + 1'b1);
      end
      if (sof) begin
        c_d.frames = W'(c_q.frames + 1'b1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      c_q <= '0;
    end else begin
      c_q <= c_d;
    end
  end

  assign frames = c_q.frames;
  assign lines  = c_q.lines;
  assign pixels = c_q.pixels;
endmodule
`default_nettype wire

// ===== verilog/vsdbg_top.sv
// Video stream debug unit: bypass, test pattern, line shaping, counters
`timescale 1ns/1ps
`default_nettype none
module vsdbg_top import vsdbg_pkg::*; #(
  parameter bit DEBUG_EN = 1'b1,
  parameter bit LITE_EN  = 1'b1
) (
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [DATA_W-1:0] s_axis_video_tdata,
  input  wire logic              s_axis_video_tuser,
  input  wire logic              s_axis_video_tlast,
  input  wire logic              s_axis_video_tvalid,
  output logic                   s_axis_video_tready,
  output logic [DATA_W-1:0]      m_axis_video_tdata,
  output logic                   m_axis_video_tuser,
  output logic                   m_axis_video_tlast,
  output logic                   m_axis_video_tvalid,
  input  wire logic              m_axis_video_tready
);
  // --------------------------------------------------------------------
  // Build options
  // --------------------------------------------------------------------
  localparam bit DBG = DEBUG_EN && LITE_EN;

  if (DEBUG_EN && !LITE_EN) begin : g_chk
    $error("vsdbg_top: debug features need the register interface");
  end

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
    merge = old;
  endfunction

  vsdbg_core_t s_q;
  vsdbg_core_t s_d;
  vsdbg_beat_t sBeat;
  vsdbg_beat_t genBeat;
  logic        genValid;
  logic        bypassOn;
  logic        patternOn;
  logic        sFire;
  logic        mFire;
  logic        wrGo;
  logic        lineEnd;
  logic [15:0] rowEff;
  logic [31:0] frameCnt;
  logic [31:0] lineCnt;
  logic [31:0] pixelCnt;
  logic [31:0] sizeWord;

  assign sBeat     = '{tdata: s_axis_video_tdata, tuser: s_axis_video_tuser,
                       tlast: s_axis_video_tlast};
  assign bypassOn  = DBG && s_q.bypass;
  assign patternOn = DBG && s_q.pattern;
  assign sizeWord  = {s_q.rows, s_q.cols};
  // Input stalls while the pattern owns the output
  assign s_axis_video_tready = !patternOn && (!s_q.oValid || m_axis_video_tready);
  assign sFire     = s_axis_video_tvalid && s_axis_video_tready;
  assign mFire     = m_axis_video_tvalid && m_axis_video_tready;
  assign wrGo      = s_axi_awvalid && s_axi_wvalid && !s_q.bValid;
  assign rowEff    = (s_axis_video_tuser || s_q.row >= s_q.rows) ? 16'h0000 : s_q.row;
  assign lineEnd   = s_axis_video_tlast || (s_q.col >= 16'(s_q.cols - 16'h0001));

  // --------------------------------------------------------------------
  // Register access and stream shaping
  // --------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (s_q.bValid && s_axi_bready) begin
      s_d.bValid = 1'b0;
    end
    if (wrGo) begin
      s_d.bValid = 1'b1;
      case (s_axi_awaddr)
        OFS_CONTROL: begin
          if (s_axi_wstrb[0]) begin
            s_d.bypass  = s_axi_wdata[BIT_BYPASS];
            s_d.pattern = s_axi_wdata[BIT_PATTERN];
          end
        end
        OFS_ERROR: begin
          if (s_axi_wstrb[0]) begin
            s_d.err = s_q.err & ~s_axi_wdata[3:0];
          end
        end
        OFS_SIZE: begin
          {s_d.rows, s_d.cols} = merge(sizeWord, s_axi_wdata, s_axi_wstrb);
        end
        default: begin
        end
      endcase
    end
    if (s_q.rValid && s_axi_rready) begin
      s_d.rValid = 1'b0;
    end
    if (s_axi_arvalid && !s_q.rValid) begin
      s_d.rValid = 1'b1;
      case (s_axi_araddr)
        OFS_CONTROL:   s_d.rData = 32'(s_q.pattern) << BIT_PATTERN | 32'(s_q.bypass) << BIT_BYPASS;
        OFS_ERROR:     s_d.rData = {28'h0000000, s_q.err};
        OFS_FRAME_CNT: s_d.rData = DBG ? frameCnt : 32'h00000000;
        OFS_LINE_CNT:  s_d.rData = DBG ? lineCnt : 32'h00000000;
        OFS_PIXEL_CNT: s_d.rData = DBG ? pixelCnt : 32'h00000000;
        OFS_SIZE:      s_d.rData = sizeWord;
        default:       s_d.rData = 32'h00000000;
      endcase
    end
    if (s_q.oValid && m_axis_video_tready && !patternOn) begin
      s_d.oValid = 1'b0;
    end
    if (sFire && bypassOn) begin
      s_d.oValid = 1'b1;
      s_d.oBeat  = sBeat;
    end else if (sFire && s_q.drop) begin
      s_d.drop = !s_axis_video_tlast;
    end else if (sFire) begin
      if (s_q.col == 16'h0000 && s_axis_video_tuser && s_q.row != 16'h0000
          && s_q.row < s_q.rows) begin
        s_d.err[BIT_SOF_EARLY] = 1'b1;
      end
      if (s_q.col == 16'h0000 && !s_axis_video_tuser && s_q.row >= s_q.rows) begin
        s_d.err[BIT_SOF_LATE] = 1'b1;
      end
      s_d.oValid      = 1'b1;
      s_d.oBeat.tdata = s_axis_video_tdata;
      s_d.oBeat.tuser = (s_q.col == 16'h0000) && (rowEff == 16'h0000);
      s_d.oBeat.tlast = lineEnd;
      if (lineEnd) begin
        s_d.col = 16'h0000;
        s_d.row = 16'(rowEff + 16'h0001);
        if (s_q.col < 16'(s_q.cols - 16'h0001)) begin
          s_d.err[BIT_SHORT] = 1'b1;
        end
        if (!s_axis_video_tlast) begin
          s_d.drop          = 1'b1;
          s_d.err[BIT_LONG] = 1'b1;
        end
      end else begin
        s_d.col = 16'(s_q.col + 16'h0001);
        s_d.row = rowEff;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_q      <= '0;
      s_q.cols <= COLS_RESET;
      s_q.rows <= ROWS_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // --------------------------------------------------------------------
  // Debug pieces and output mux
  // --------------------------------------------------------------------
  if (DBG) begin : g_dbg
    vsdbg_pattern u_pattern (
      .ref_clk (ref_clk),
      .reset   (reset),
      .enable  (patternOn),
      .cols    (s_q.cols),
      .rows    (s_q.rows),
      .ready   (m_axis_video_tready),
      .valid   (genValid),
      .beat    (genBeat)
    );
    vsdbg_tput #(.W(CNT_W)) u_tput (
      .ref_clk (ref_clk),
      .reset   (reset),
      .fire    (mFire),
      .sof     (m_axis_video_tuser),
      .eol     (m_axis_video_tlast),
      .frames  (frameCnt),
      .lines   (lineCnt),
      .pixels  (pixelCnt)
    );
  end else begin : g_nodbg
    // Logic omitted entirely when not built in
    assign genValid = 1'b0;
    assign genBeat  = '0;
    assign frameCnt = 32'h00000000;
    assign lineCnt  = 32'h00000000;
    assign pixelCnt = 32'h00000000;
  end

  assign m_axis_video_tvalid = patternOn ? genValid : s_q.oValid;
  assign m_axis_video_tdata  = patternOn ? genBeat.tdata : s_q.oBeat.tdata;
  assign m_axis_video_tuser  = patternOn ? genBeat.tuser : s_q.oBeat.tuser;
  assign m_axis_video_tlast  = patternOn ? genBeat.tlast : s_q.oBeat.tlast;
  assign s_axi_awready = wrGo;
  assign s_axi_wready  = wrGo;
  assign s_axi_bvalid  = s_q.bValid;
  assign s_axi_bresp   = RESP_OKAY;
  assign s_axi_arready = !s_q.rValid;
  assign s_axi_rvalid  = s_q.rValid;
  assign s_axi_rdata   = s_q.rData;
  assign s_axi_rresp   = RESP_OKAY;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  property p_bypass_copy;
    (bypassOn && sFire) |=> (s_q.oValid && s_q.oBeat == $past(sBeat));
  endproperty
  a_bypass_copy: assert property (p_bypass_copy) else $error("bypass beat altered");

  // Checked at the pins, not the output stage, so a wrong mux select shows up
  property p_bypass_mode;
    (bypassOn && !patternOn && sFire ##1 !patternOn)
      |-> (m_axis_video_tvalid
           && {m_axis_video_tdata, m_axis_video_tuser, m_axis_video_tlast} == $past(sBeat));
  endproperty
  a_bypass_mode: assert property (p_bypass_mode) else $error("bypass output not from path");

  property p_pattern_mux;
    patternOn |-> (m_axis_video_tvalid == genValid && !s_axis_video_tready);
  endproperty
  a_pattern_mux: assert property (p_pattern_mux) else $error("pattern mux wrong");

  property p_pattern_hold;
    (patternOn && m_axis_video_tvalid && !m_axis_video_tready ##1 patternOn)
      |-> (m_axis_video_tvalid && $stable(m_axis_video_tdata) && $stable(m_axis_video_tlast));
  endproperty
  a_pattern_hold: assert property (p_pattern_hold) else $error("pattern moved under stall");

  property p_drop;
    (!bypassOn && s_q.drop && sFire) |=> (s_q.oValid == 1'b0 || $stable(s_q.oBeat));
  endproperty
  a_drop: assert property (p_drop) else $error("overlong pixel passed");

  property p_long;
    (!bypassOn && !s_q.drop && sFire && !s_axis_video_tlast
      && s_q.col == 16'(s_q.cols - 16'h0001))
      |=> (s_q.drop && s_q.err[BIT_LONG] && s_q.oBeat.tlast) ##1 s_q.err[BIT_LONG];
  endproperty
  a_long: assert property (p_long) else $error("long line not handled");

  property p_short;
    (!bypassOn && !s_q.drop && sFire && s_axis_video_tlast
      && s_q.col < 16'(s_q.cols - 16'h0001)) |=> s_q.err[BIT_SHORT] && s_q.col == 16'h0000;
  endproperty
  a_short: assert property (p_short) else $error("short line not flagged");

  property p_sof_early;
    (!bypassOn && !s_q.drop && sFire && s_axis_video_tuser && s_q.col == 16'h0000
      && s_q.row != 16'h0000 && s_q.row < s_q.rows) |=> s_q.err[BIT_SOF_EARLY];
  endproperty
  a_sof_early: assert property (p_sof_early) else $error("early frame not flagged");

  property p_pixel_cnt;
    DBG && mFire |=> pixelCnt == 32'($past(pixelCnt) + 32'h00000001);
  endproperty
  a_pixel_cnt: assert property (p_pixel_cnt) else $error("pixel count missed");

  property p_frame_cnt;
    DBG && !(mFire && m_axis_video_tuser) |=> $stable(frameCnt);
  endproperty
  a_frame_cnt: assert property (p_frame_cnt) else $error("frame count moved");

  property p_line_cnt;
    DBG && mFire && m_axis_video_tlast |=> lineCnt == 32'($past(lineCnt) + 32'h00000001);
  endproperty
  a_line_cnt: assert property (p_line_cnt) else $error("line count missed");

  c_bypass:  cover property (bypassOn && mFire && m_axis_video_tlast);
  c_pattern: cover property (patternOn && mFire && m_axis_video_tuser);
  c_drop:    cover property (s_q.drop ##1 !s_q.drop);
  c_short:   cover property ($rose(s_q.err[BIT_SHORT]));
endmodule
`default_nettype wire

// ===== test/vsdbg_sink.sv
// Downstream stream partner model with random back-pressure
`timescale 1ns/1ps
`default_nettype none
module vsdbg_sink import vsdbg_pkg::*; (
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic              tvalid,
  input  wire logic [DATA_W-1:0] tdata,
  input  wire logic              tuser,
  input  wire logic              tlast,
  output logic                   tready
);
  vsdbg_beat_t got[$];
  // ------------------------------------------------------------
  // Stall about one cycle in three, same clock as the unit
  // ------------------------------------------------------------
  initial tready = 1'b0;
  always @(negedge ref_clk) begin
    tready <= ($urandom % 3 != 0);
  end
  always @(posedge ref_clk) begin
    if (!reset && tvalid && tready) begin
      got.push_back({tdata, tuser, tlast});
    end
  end
endmodule
`default_nettype wire

// ===== test/test_video_stream_debug_unit.sv
// Self-checking bench for the video stream debug unit
`timescale 1ns/1ps
`default_nettype none
module test_video_stream_debug_unit;
  import vsdbg_pkg::*;
  logic              ref_clk, reset;
  logic [7:0]        s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready;
  logic [DATA_W-1:0] sTdata, mTdata;
  logic              sTuser, sTlast, sTvalid, sTready, mTuser, mTlast, mTvalid, mTready;
  int                err_total, samples_checked;
  vsdbg_beat_t       sent[$];

  vsdbg_top dut (.ref_clk(ref_clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axis_video_tdata(sTdata), .s_axis_video_tuser(sTuser),
    .s_axis_video_tlast(sTlast), .s_axis_video_tvalid(sTvalid), .s_axis_video_tready(sTready),
    .m_axis_video_tdata(mTdata), .m_axis_video_tuser(mTuser), .m_axis_video_tlast(mTlast),
    .m_axis_video_tvalid(mTvalid), .m_axis_video_tready(mTready));

  vsdbg_sink sink (.ref_clk(ref_clk), .reset(reset), .tvalid(mTvalid), .tdata(mTdata),
    .tuser(mTuser), .tlast(mTlast), .tready(mTready));

  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    s_axi_awaddr = a;
    s_axi_wdata = d;
    s_axi_awvalid = 1'b1;
    s_axi_wvalid = 1'b1;
    do @(posedge ref_clk); while (!s_axi_awready);
    @(negedge ref_clk);
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b1;
    do @(posedge ref_clk); while (!s_axi_bvalid);
    check(s_axi_bresp, RESP_OKAY, "write response");
    @(negedge ref_clk);
    s_axi_bready = 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string w);
    logic [31:0] d;
    @(negedge ref_clk);
    s_axi_araddr = a;
    s_axi_arvalid = 1'b1;
    do @(posedge ref_clk); while (!s_axi_arready);
    @(negedge ref_clk);
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b1;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    check(s_axi_rresp, RESP_OKAY, "read response");
    @(negedge ref_clk);
    s_axi_rready = 1'b0;
    check(d, e, w);
  endtask
  task automatic counters(input int f, input int l, input int p);
    rdchk(OFS_FRAME_CNT, f, "frames");
    rdchk(OFS_LINE_CNT, l, "lines");
    rdchk(OFS_PIXEL_CNT, p, "pixels");
  endtask
  // ------------------------------------------------------------
  // Stream source, random data and random gaps
  // ------------------------------------------------------------
  task automatic line(input int n, input logic sof);
    for (int i = 0; i < n; i++) begin
      @(negedge ref_clk);
      if ($urandom % 4 == 0) begin
        sTvalid = 1'b0;
        @(negedge ref_clk);
      end
      sTdata = DATA_W'($urandom);
      sTuser = sof && i == 0;
      sTlast = (i == n - 1);
      sTvalid = 1'b1;
      do @(posedge ref_clk); while (!sTready);
      sent.push_back({sTdata, sTuser, sTlast});
    end
    @(negedge ref_clk);
    sTvalid = 1'b0;
  endtask
  // Bounded wait; a shortfall shows up as a count mismatch
  task automatic waitBeats(input int n);
    for (int k = 0; k < 20000 && sink.got.size() < n; k++) @(posedge ref_clk);
    repeat (4) @(posedge ref_clk);
    check(sink.got.size(), n, "beat count");
  endtask
  function automatic vsdbg_beat_t expPix(input int c, input int r, input int cols);
    logic [2:0] bar;
    logic [7:0] v;
    bar = 3'(c / BAR_WIDTH);
    v = 8'(c) + 8'(r);
    expPix.tuser = (c == 0 && r == 0);
    expPix.tlast = (c == cols - 1);
    if (r < BAR_LINES) expPix.tdata = {{8{bar[0]}}, {8{bar[1]}}, {8{bar[2]}}};
    else expPix.tdata = {v, v, v};
  endfunction
  // Whole frame from the generator, sink stalling at random throughout
  task automatic patternFrame(input int cols, input int rows);
    sink.got.delete();
    wr(OFS_SIZE, {16'(rows), 16'(cols)});
    wr(OFS_CONTROL, 32'h20);
    check(sTready, 1'b0, "upstream ready in pattern");
    // Generator loops frames: wait into the next frame and check its restart
    for (int k = 0; k < 20000 && sink.got.size() <= cols * rows; k++) @(posedge ref_clk);
    check(sink.got.size() > cols * rows, 1'b1, "pattern beat count");
    for (int i = 0; i < cols * rows; i++) begin
      check(sink.got[i], expPix(i % cols, i / cols, cols), "pattern");
    end
    check(sink.got[cols * rows], expPix(0, 0, cols), "pattern restart");
    wr(OFS_CONTROL, 32'h0);
  endtask
  // ------------------------------------------------------------
  // Clock, watchdog, main sequence
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    #400000;
    err_total++;
    $display("wrong value at %0t: watchdog expired", $time);
    conclude();
  end
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, sTdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {sTuser, sTlast, sTvalid} = '0;
    s_axi_wstrb = 4'hf;
    err_total = 0;
    samples_checked = 0;
    void'($urandom(32'h37ef));
    reset = 1'b1;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    reset = 1'b0;
    counters(0, 0, 0);
    rdchk(OFS_ERROR, 32'h0, "error at reset");
    rdchk(OFS_SIZE, {ROWS_RESET, COLS_RESET}, "size at reset");
    rdchk(8'h40, 32'h0, "unmapped");
    // Passthrough: three lines of five, compared beat by beat
    wr(OFS_CONTROL, 32'h10);
    rdchk(OFS_CONTROL, 32'h10, "control readback");
    for (int r = 0; r < 3; r++) line(5, r == 0);
    waitBeats(15);
    for (int i = 0; i < 15; i++) check(sink.got[i], sent[i], "bypass beat");
    counters(1, 3, 15);
    // Normal path, 4x2: long, short, missing SOF, early SOF
    wr(OFS_CONTROL, 32'h0);
    wr(OFS_SIZE, 32'h00020004);
    wr(OFS_ERROR, 32'hf);
    sink.got.delete();
    line(7, 1'b1);
    line(2, 1'b0);
    line(4, 1'b0);
    line(4, 1'b1);
    waitBeats(14);
    for (int i = 0; i < 14; i++) begin
      check({sink.got[i].tuser, sink.got[i].tlast},
        {i == 0 || i == 6 || i == 10, i == 3 || i == 5 || i == 9 || i == 13}, "markers");
    end
    rdchk(OFS_ERROR, 32'hf, "error flags");
    wr(OFS_ERROR, 32'hf);
    rdchk(OFS_ERROR, 32'h0, "error cleared");
    counters(4, 7, 29);
    wr(OFS_FRAME_CNT, 32'h1234);
    rdchk(OFS_FRAME_CNT, 32'h4, "read-only frames");
    // Every bar colour on row 0, then ramp rows past the bars
    patternFrame(520, 2);
    patternFrame(4, 258);
    // Counters restart after a core reset in mid-run
    @(negedge ref_clk);
    reset = 1'b1;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    reset = 1'b0;
    counters(0, 0, 0);
    conclude();
  end
endmodule
`default_nettype wire
